// *** cvsd_defines.svh ***
// shared constants for the delta-modulation audio path
`ifndef CVSD_DEFINES_SVH
`define CVSD_DEFINES_SVH
`define CVSD_FIFO_DEPTH 3
`define CVSD_BYTE_BITS 8
`define CVSD_BIT_CNT_W 3
`define CVSD_LAST_BIT 3'h7
`define CVSD_RUN_THRESH 4'h3
`define CVSD_RUN_W 4
`define CVSD_STEP_W 4
`define CVSD_STEP_MIN 4'h1
`define CVSD_STEP_MAX 4'h8
`define CVSD_DIV_W 16
`define CVSD_DIV_RESET 16'h05db
`define CVSD_VOL_RATE_NS 50000
`define CVSD_VOL_SUBDIV 16
`define CVSD_CLK_NS 20
`define CVSD_VOL_DIV_RESET 8'h04
`define CVSD_VOL_PAT_RESET 8'h00
`endif

// *** cvsd_pkg.sv ***
// types for the delta-modulation audio path
package cvsd_pkg;
   typedef enum logic [1:0] {
      CVSD_DIR_PLAY = 2'h1,
      CVSD_DIR_REC = 2'h2
   } cvsd_dir_t;
   typedef logic [7:0] cvsd_byte_t;
endpackage

// *** cvsd_link.sv ***
// link-clock side: shifts bits to/from the codec, tracks the slope step
`timescale 1ns/1ps
`default_nettype none
`include "cvsd_defines.svh"
module cvsd_link
   import cvsd_pkg::*;
(
   input wire logic link_clk_i,
   input wire logic link_rst_n_i,
   input wire logic play_i,
   input wire logic tx_have_i,
   input wire cvsd_pkg::cvsd_byte_t tx_byte_i,
   output logic tx_take_o,
   input wire logic rx_bit_i,
   output logic tx_bit_o,
   output cvsd_pkg::cvsd_byte_t rx_byte_o,
   output logic rx_tgl_o,
   output logic [`CVSD_STEP_W-1:0] step_o
);
   import cvsd_pkg::*;
   logic [`CVSD_BIT_CNT_W-1:0] bit_cnt;
   cvsd_byte_t sh;
   logic last_bit;
   logic [`CVSD_RUN_W-1:0] run;
   logic cur_bit;
   assign cur_bit = play_i ? sh[0] : rx_bit_i;
   assign tx_bit_o = sh[0];
   assign tx_take_o = play_i && (bit_cnt == `CVSD_LAST_BIT);

   // lsb first; play loads next byte after the eighth bit
   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n_i) begin
         bit_cnt <= '0;
         sh <= '0;
         rx_byte_o <= '0;
         rx_tgl_o <= 1'b0;
      end else begin
         bit_cnt <= bit_cnt + 3'h1;
         if (play_i) begin
            if (bit_cnt == `CVSD_LAST_BIT)
               sh <= tx_have_i ? tx_byte_i : '0;
            else
               sh <= {1'b0, sh[7:1]};
         end else begin
            sh <= {rx_bit_i, sh[7:1]};
            if (bit_cnt == `CVSD_LAST_BIT) begin
               rx_byte_o <= {rx_bit_i, sh[7:1]};
               rx_tgl_o <= ~rx_tgl_o;
            end
         end
      end
   end

   // run length of equal bits grows the step up to its limit
   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n_i) begin
         last_bit <= 1'b0;
         run <= '0;
         step_o <= `CVSD_STEP_MIN;
      end else begin
         last_bit <= cur_bit;
         if (cur_bit == last_bit) begin
            if (run != {`CVSD_RUN_W{1'b1}})
               run <= run + 4'h1;
         end else begin
            run <= 4'h1;
         end
         if (cur_bit == last_bit && run >= `CVSD_RUN_THRESH - 4'h1) begin
            if (step_o != `CVSD_STEP_MAX)
               step_o <= step_o + 4'h1;
         end else if (cur_bit != last_bit) begin
            step_o <= `CVSD_STEP_MIN;
         end
      end
   end

   // properties below all run on the link clock
   default clocking link_cb @(posedge link_clk_i);
   endclocking
   default disable iff (!link_rst_n_i);

   // third equal bit with room left to grow; a shift inside a byte
   sequence run_grows;
      cur_bit == last_bit && run >= `CVSD_RUN_THRESH - 4'h1 &&
      step_o != `CVSD_STEP_MAX;
   endsequence
   sequence mid_byte;
      play_i && bit_cnt != `CVSD_LAST_BIT && $stable(play_i);
   endsequence

   chk_step_cap: assert property (step_o <= `CVSD_STEP_MAX)
      else $error("step above limit");
   chk_step_grow: assert property (
      run_grows |=> $past(step_o) + 4'h1 == step_o)
      else $error("step did not grow on run");
   chk_lsb_first: assert property (
      mid_byte |=> tx_bit_o == $past(sh[1]))
      else $error("bit order wrong");
endmodule // cvsd_link
`default_nettype wire

// *** cvsd_audio_serial_path.sv ***
// audio path: byte queue, shift clock, codec direction, volume gate
// Functional notes
// - queue holds up to three bytes
// - playback serialises bytes to the codec
// - record assembles codec bits into bytes
// - bytes shift out lsb first
// - status shows queue can take data
// - direction output selects decode or encode
// - shift clock from software-set timer divider
// - one bit per link clock period
// - zero raises output during playback, one lowers it
// - runs of three grow step gain
// - step keeps growing until maximum
// - recirculating pattern sets eight levels plus off
`timescale 1ns/1ps
`default_nettype none
`include "cvsd_defines.svh"
module cvsd_audio_serial_path
   import cvsd_pkg::*;
#(
   parameter int DEPTH = `CVSD_FIFO_DEPTH
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic play_i,
   input wire logic wr_i,
   input wire cvsd_pkg::cvsd_byte_t wr_data_i,
   output logic wr_ready_o,
   output logic fifo_empty_o,
   output cvsd_pkg::cvsd_byte_t rd_data_o,
   output logic rd_valid_o,
   input wire logic rd_i,
   input wire logic [`CVSD_DIV_W-1:0] clk_div_i,
   input wire logic clk_div_load_i,
   output logic shift_clock_port_bit_o,
   output cvsd_pkg::cvsd_dir_t codec_dir_o,
   output logic codec_tx_bit_o,
   input wire logic codec_rx_bit_i,
   output logic integ_up_o,
   output logic [`CVSD_STEP_W-1:0] step_o,
   input wire logic [7:0] vol_pattern_i,
   input wire logic vol_load_i,
   output logic vol_gate_o,
   output logic [3:0] vol_level_o
);
   import cvsd_pkg::*;

   // byte queue, reference clock side
   cvsd_byte_t mem [DEPTH];
   logic [1:0] wr_ptr, rd_ptr, count;
   logic full, empty, push, pop;
   assign full = (count == 2'(DEPTH));
   assign empty = (count == 2'h0);
   assign wr_ready_o = !full && play_i;
   assign fifo_empty_o = empty;
   assign push = wr_i && wr_ready_o;

   // link-side byte request crosses as a toggle
   logic take_tgl_l;
   logic [2:0] take_sync;
   assign pop = (take_sync[2] ^ take_sync[1]) && !empty;

   // front byte read combinationally from the queue head, valid while not empty
   cvsd_byte_t front;
   logic front_have;
   assign front = mem[rd_ptr];
   assign front_have = !empty;

   function automatic logic [1:0] ptr_inc(input logic [1:0] p);
      return (p == 2'(DEPTH - 1)) ? 2'h0 : p + 2'h1;
   endfunction

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= wr_data_i;
            wr_ptr <= ptr_inc(wr_ptr);
         end
         if (pop)
            rd_ptr <= ptr_inc(rd_ptr);
         count <= count + 2'(push) - 2'(pop);
      end
   end

   // stage the front byte to the link so it is stable when taken
   cvsd_byte_t stage;
   logic stage_have;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         stage <= '0;
         stage_have <= 1'b0;
      end else begin
         stage <= front;
         stage_have <= front_have;
      end
   end

   // play level into link domain
   logic [1:0] play_sync_l;
   logic [1:0] have_sync_l;
   logic link_rst_n;
   logic [1:0] rst_sync_l;
   always_ff @(posedge link_clk_i) begin
      rst_sync_l <= {rst_sync_l[0], rst_n_i};
      play_sync_l <= {play_sync_l[0], play_i};
      have_sync_l <= {have_sync_l[0], stage_have};
   end
   assign link_rst_n = rst_sync_l[1];

   logic tx_take;
   cvsd_byte_t rx_byte_l;
   logic rx_tgl_l;
   cvsd_link u_link (
      .link_clk_i(link_clk_i),
      .link_rst_n_i(link_rst_n),
      .play_i(play_sync_l[1]),
      .tx_have_i(have_sync_l[1]),
      .tx_byte_i(stage),
      .tx_take_o(tx_take),
      .rx_bit_i(codec_rx_bit_i),
      .tx_bit_o(codec_tx_bit_o),
      .rx_byte_o(rx_byte_l),
      .rx_tgl_o(rx_tgl_l),
      .step_o(step_o)
   );
   // one bit per link clock period

   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n)
         take_tgl_l <= 1'b0;
      else if (tx_take && have_sync_l[1])
         take_tgl_l <= ~take_tgl_l;
   end

   // toggle crossings back to reference clock
   logic [2:0] rx_sync;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         take_sync <= '0;
         rx_sync <= '0;
      end else begin
         take_sync <= {take_sync[1:0], take_tgl_l};
         rx_sync <= {rx_sync[1:0], rx_tgl_l};
      end
   end

   // received byte held for the cpu; rx_byte_l is stable for 8 link clocks
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rd_data_o <= '0;
         rd_valid_o <= 1'b0;
      end else if (rx_sync[2] ^ rx_sync[1]) begin
         rd_data_o <= rx_byte_l;
         rd_valid_o <= 1'b1;
      end else if (rd_i) begin
         rd_valid_o <= 1'b0;
      end
   end

   // codec direction and integrator sense
   logic [1:0] txb_sync;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         codec_dir_o <= CVSD_DIR_REC;
         txb_sync <= '0;
         integ_up_o <= 1'b0;
      end else begin
         codec_dir_o <= play_i ? CVSD_DIR_PLAY : CVSD_DIR_REC;
         txb_sync <= {txb_sync[0], codec_tx_bit_o};
         integ_up_o <= play_i && !txb_sync[1];
      end
   end

   // timer-driven shift clock: toggles every divider expiry
   logic [`CVSD_DIV_W-1:0] div_reload, div_cnt;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         div_reload <= `CVSD_DIV_RESET;
         div_cnt <= `CVSD_DIV_RESET;
         shift_clock_port_bit_o <= 1'b0;
      end else begin
         if (clk_div_load_i)
            div_reload <= clk_div_i;
         if (div_cnt == '0) begin
            div_cnt <= div_reload;
            shift_clock_port_bit_o <= ~shift_clock_port_bit_o;
         end else begin
            div_cnt <= div_cnt - 16'h1;
         end
      end
   end

   // volume gate: 8-bit pattern recirculates, one bit per slot
   localparam int VOL_SLOT_CYC =
      `CVSD_VOL_RATE_NS / `CVSD_BYTE_BITS / `CVSD_CLK_NS / `CVSD_VOL_SUBDIV;
   localparam logic [7:0] VOL_SLOT = 8'(VOL_SLOT_CYC);
   logic [7:0] vol_pat, vol_cnt;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         vol_pat <= `CVSD_VOL_PAT_RESET;
         vol_cnt <= '0;
      end else if (vol_load_i) begin
         vol_pat <= vol_pattern_i;
         vol_cnt <= '0;
      end else if (vol_cnt >= VOL_SLOT) begin
         vol_cnt <= '0;
         vol_pat <= {vol_pat[0], vol_pat[7:1]};
      end else begin
         vol_cnt <= vol_cnt + 8'h1;
      end
   end

   // gate cycle is fast enough for the recommended switching rate
   function automatic logic [3:0] ones(input logic [7:0] v);
      logic [3:0] n;
      n = '0;
      for (int i = 0; i < 8; i++)
         n = n + 4'(v[i]);
      return n;
   endfunction

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         vol_gate_o <= 1'b0;
         vol_level_o <= '0;
      end else begin
         vol_gate_o <= vol_pat[0];
         vol_level_o <= ones(vol_pat);
      end
   end

   // properties below all run on the reference clock
   default clocking ref_cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // building blocks: lone push, lone pop, idle slots, byte arrival
   sequence push_only;
      push && !pop;
   endsequence
   sequence pop_only;
      pop && !push;
   endsequence
   sequence silent_two;
      (vol_pat == 8'h00) [*2];
   endsequence
   sequence byte_arrives;
      rx_sync[2] ^ rx_sync[1];
   endsequence

   // queue
   chk_fifo_bound: assert property (count <= 2'(DEPTH))
      else $error("queue over depth");
   chk_push_count: assert property (
      push_only |=> count == $past(count) + 2'h1)
      else $error("push lost");
   chk_pop_count: assert property (
      pop_only |=> count == $past(count) - 2'h1)
      else $error("pop lost");
   chk_ready_full: assert property (full |-> !wr_ready_o)
      else $error("ready while full");
   chk_ready_rec: assert property (!play_i |-> !wr_ready_o)
      else $error("ready in record mode");

   // codec direction and integrator sense
   chk_dir_follow: assert property (
      $rose(play_i) |=> codec_dir_o == CVSD_DIR_PLAY)
      else $error("direction not play");
   chk_dir_rec: assert property (
      $fell(play_i) |=> codec_dir_o == CVSD_DIR_REC)
      else $error("direction not record");
   chk_integ_sense: assert property (
      play_i && !txb_sync[1] |=> integ_up_o)
      else $error("integrator sense wrong");

   // shift clock
   chk_clk_toggle: assert property (
      (div_cnt == '0) |=>
      shift_clock_port_bit_o != $past(shift_clock_port_bit_o))
      else $error("shift clock missed toggle");
   chk_div_reload: assert property (
      (div_cnt == '0) |=> div_cnt == $past(div_reload))
      else $error("divider not reloaded");

   // received byte
   chk_rx_valid: assert property (byte_arrives |=> rd_valid_o)
      else $error("byte not presented");
   chk_rd_hold: assert property (
      rd_valid_o && !rd_i && !(rx_sync[2] ^ rx_sync[1])
      |=> rd_valid_o && $stable(rd_data_o))
      else $error("received byte not held");
   chk_rd_clear: assert property (
      rd_i && !(rx_sync[2] ^ rx_sync[1]) |=> !rd_valid_o)
      else $error("received byte not released");

   // volume
   chk_vol_off: assert property (silent_two |=> !vol_gate_o)
      else $error("gate on at silence");
   chk_vol_keep: assert property (
      !vol_load_i |=> ones(vol_pat) == ones($past(vol_pat)))
      else $error("pattern not recirculating");
   chk_gate_follow: assert property (
      vol_gate_o == $past(vol_pat[0]))
      else $error("gate not following pattern");
   chk_level_follow: assert property (
      vol_level_o == ones($past(vol_pat)))
      else $error("level not following pattern");
endmodule // cvsd_audio_serial_path
`default_nettype wire

// *** cvsd_codec_model.sv ***
// codec stand-in: captures played bits and sends recorded bits
`timescale 1ns/1ps
`default_nettype none
module cvsd_codec_model
   import cvsd_pkg::*;
(
   input wire logic link_clk_i,
   input wire cvsd_pkg::cvsd_dir_t dir_i,
   input wire logic tx_bit_i,
   input wire cvsd_pkg::cvsd_byte_t rx_pat_i,
   output logic rx_bit_o,
   output cvsd_pkg::cvsd_byte_t seen_o
);
   logic [2:0] idx;
   initial begin
      rx_bit_o = 1'b0;
      seen_o = 8'h00;
      idx = 3'h0;
   end
   // one bit taken per link clock rise, the oldest ends in bit 0
   always @(posedge link_clk_i) begin
      if (dir_i == CVSD_DIR_PLAY) begin
         seen_o <= {tx_bit_i, seen_o[7:1]};
      end
   end
   // recorded bits change on the fall; the line toggles while not encoding
   always @(negedge link_clk_i) begin
      if (dir_i == CVSD_DIR_REC) begin
         rx_bit_o <= rx_pat_i[idx];
         idx <= idx + 3'h1;
      end else begin
         rx_bit_o <= ~rx_bit_o;
      end
   end
endmodule // cvsd_codec_model
`default_nettype wire

// *** cvsd_audio_serial_path_tb.sv ***
// self-checking bench for the audio serial path
`timescale 1ns/1ps
`default_nettype none
`include "cvsd_defines.svh"
module cvsd_audio_serial_path_tb;
   import cvsd_pkg::*;
   logic ref_clk_i, rst_n_i, link_clk_i, play_i, wr_i, wr_ready_o;
   logic fifo_empty_o, rd_valid_o, rd_i, clk_div_load_i, shift_o;
   logic tx_bit, rx_bit, integ_up_o, vol_load_i, vol_gate_o;
   cvsd_byte_t wr_data_i, rd_data_o, rx_pat, seen, b1;
   cvsd_dir_t codec_dir_o;
   logic [15:0] clk_div_i;
   logic [3:0] step_o, vol_level_o;
   logic [7:0] vol_pattern_i;
   int n_errors, cmp_count, n;
   cvsd_audio_serial_path u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .link_clk_i(link_clk_i), .play_i(play_i), .wr_i(wr_i),
      .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o),
      .fifo_empty_o(fifo_empty_o), .rd_data_o(rd_data_o),
      .rd_valid_o(rd_valid_o), .rd_i(rd_i), .clk_div_i(clk_div_i),
      .clk_div_load_i(clk_div_load_i), .shift_clock_port_bit_o(shift_o),
      .codec_dir_o(codec_dir_o), .codec_tx_bit_o(tx_bit),
      .codec_rx_bit_i(rx_bit), .integ_up_o(integ_up_o), .step_o(step_o),
      .vol_pattern_i(vol_pattern_i), .vol_load_i(vol_load_i),
      .vol_gate_o(vol_gate_o), .vol_level_o(vol_level_o));
   cvsd_codec_model u_codec (.link_clk_i(link_clk_i), .dir_i(codec_dir_o),
      .tx_bit_i(tx_bit), .rx_pat_i(rx_pat), .rx_bit_o(rx_bit),
      .seen_o(seen));
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #7;
      forever #80 link_clk_i = ~link_clk_i;
   end
   task automatic check(input string what, input logic [15:0] seen_v,
                        input logic [15:0] exp_v);
      cmp_count++;
      if (seen_v !== exp_v) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp_v, seen_v);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic t_play();
      play_i = 1'b1;
      repeat (200) @(negedge ref_clk_i);
      check("dir", 16'(codec_dir_o), 16'(CVSD_DIR_PLAY));
      check("step", 16'(step_o), 16'(`CVSD_STEP_MAX));
      check("up", 16'(integ_up_o), 16'h1);
      wr_i = 1'b1;
      wr_data_i = 8'h11;
      @(negedge ref_clk_i);
      wr_i = 1'b0;
      n = 0;
      while (fifo_empty_o !== 1'b1 && n < 200) begin
         @(negedge ref_clk_i);
         n++;
      end
      wr_i = 1'b1;
      wr_data_i = 8'ha5;
      @(negedge ref_clk_i);
      wr_data_i = 8'h3c;
      @(negedge ref_clk_i);
      wr_data_i = 8'hc3;
      @(negedge ref_clk_i);
      wr_i = 1'b0;
      check("ready", 16'(wr_ready_o), 16'h0);
      check("empty", 16'(fifo_empty_o), 16'h0);
      n = 0;
      while (seen !== 8'h11 && n < 40) begin
         @(negedge link_clk_i);
         n++;
      end
      check("first", 16'(seen), 16'h11);
      repeat (8) @(negedge link_clk_i);
      check("b0", 16'(seen), 16'ha5);
      check("stp1", 16'(step_o), 16'(`CVSD_STEP_MIN));
      repeat (8) @(negedge link_clk_i);
      check("b1", 16'(seen), 16'h3c);
      repeat (8) @(negedge link_clk_i);
      check("b2", 16'(seen), 16'hc3);
      @(negedge ref_clk_i);
      check("refill", 16'(wr_ready_o), 16'h1);
   endtask
   task automatic t_rec();
      play_i = 1'b0;
      rx_pat = 8'h01;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         while (rd_valid_o !== 1'b1 && n < 300) begin
            @(negedge ref_clk_i);
            n++;
         end
         if (k == 1) b1 = rd_data_o;
         if (k == 2) check("rx", 16'(rd_data_o), 16'(b1));
         rd_i = 1'b1;
         @(negedge ref_clk_i);
         rd_i = 1'b0;
         @(negedge ref_clk_i);
         check("rdv", 16'(rd_valid_o), 16'h0);
      end
      check("dir", 16'(codec_dir_o), 16'(CVSD_DIR_REC));
      check("ones", 16'($countones(b1)), 16'h1);
   endtask
   task automatic t_div();
      logic prev;
      clk_div_i = 16'h0004;
      clk_div_load_i = 1'b1;
      @(negedge ref_clk_i);
      clk_div_load_i = 1'b0;
      for (int k = 0; k < 3; k++) begin
         prev = shift_o;
         n = 0;
         while (shift_o === prev && n < 1600) begin
            @(negedge ref_clk_i);
            n++;
         end
      end
      check("half", 16'(n), 16'h5);
   endtask
   task automatic t_vol(input logic [7:0] pat, input int ones);
      vol_pattern_i = pat;
      vol_load_i = 1'b1;
      @(negedge ref_clk_i);
      vol_load_i = 1'b0;
      repeat (30) @(negedge ref_clk_i);
      check("level", 16'(vol_level_o), 16'(ones));
      n = 0;
      repeat (160) begin
         @(negedge ref_clk_i);
         n += int'(vol_gate_o === 1'b1);
      end
      check("duty", 16'(n), 16'(20 * ones));
   endtask
   initial begin
      n_errors = 0;
      repeat (20000) @(posedge ref_clk_i);
      n_errors++;
      conclude();
   end
   initial begin
      {rst_n_i, play_i, wr_i, rd_i, clk_div_load_i, vol_load_i} = 6'h00;
      {wr_data_i, rx_pat, vol_pattern_i} = 24'h000000;
      clk_div_i = 16'h0000;
      cmp_count = 0;
      // eight link periods also satisfy the link-side reset sync
      repeat (8) @(posedge link_clk_i);
      @(negedge ref_clk_i);
      check("rst_empty", 16'(fifo_empty_o), 16'h1);
      check("rst_dir", 16'(codec_dir_o), 16'(CVSD_DIR_REC));
      check("rst_step", 16'(step_o), 16'(`CVSD_STEP_MIN));
      check("rst_gate", 16'(vol_gate_o), 16'h0);
      rst_n_i = 1'b1;
      repeat (4) @(negedge link_clk_i);
      @(negedge ref_clk_i);
      t_play();
      t_rec();
      t_div();
      t_vol(8'h00, 0);
      t_vol(8'h01, 1);
      t_vol(8'h0f, 4);
      t_vol(8'h7f, 7);
      conclude();
   end
endmodule // cvsd_audio_serial_path_tb
`default_nettype wire
